// ### core/amcs_top.sv
/*
  Modem control/status register block with Wishbone slave, line-change detect,
  receive-done flag and interrupt logic.
  Assumes modem lines already synchronised to clk_i; the character engine gives
  a one-cycle rx_char_complete pulse and the received byte beside it.
*/
// The Wishbone register port and the register offsets were decided locally.
// Function
// R1: line changes set line-change flag bit 15
// R2: init or csr read clears line-change flag
// R3: flag and bit 05 request vector 330; irq_o also needs mask register bit 0, which init clears
// R4: bit 14 reads ring indication
// R5: bit 13 follows clear-to-send input
// R6: bit 12 shows carrier present
// R7: bit 10 reads reverse-channel input space
// R8: bit 09 mirrors modem-ready, toggles flag
// R9: bit 07 sets on char, irq with 06; irq_o also needs mask register bit 1, which init clears
// R10: rx buffer access or init clears 07
// R11: bit 06 receive interrupt enable, init clears; with 06 clear a masked-in receive status bit still raises irq_o
// R12: bit 05 line-change interrupt enable, init clears; with 05 clear a masked-in line-change status bit still raises irq_o
// R13: bit 03 drives reverse-channel space, init clears
// R14: bit 02 drives request-to-send, init clears
// R15: bit 01 drives terminal-ready, init clears
// R16: after init run async with defaults
// R17: unused bits read zero, ignore writes
module amcs_top #(
  parameter int DATA_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // modem lines
  input wire amcs_pkg::amcs_modem_in_t modem_i,
  output amcs_pkg::amcs_modem_out_t modem_o,
  // character engine
  input wire logic rx_char_complete_i,
  input wire logic [DATA_W-1:0] rx_data_i,
  output logic rx_data_read_o,
  output logic async_mode_o,
  // interrupt
  output logic irq_o,
  output logic [8:0] irq_vector_o
);

  // the data buffer and its read path are one byte wide at most
  if (DATA_W < 1 || DATA_W > 8) begin : g_bad_width
    $error("amcs_top: DATA_W must be 1..8");
  end

  amcs_pkg::amcs_modem_in_t prev_q;
  logic line_change_flag_q;
  logic rx_char_complete_q;
  logic rx_irq_enable_q;
  logic line_change_irq_enable_q;
  amcs_pkg::amcs_modem_out_t ctl_q;
  logic [DATA_W-1:0] rx_data_holding_reg_q;
  logic [amcs_pkg::AMCS_EV_W-1:0] ev_stat_q;
  logic [amcs_pkg::AMCS_EV_W-1:0] ev_mask_q;

  logic req;
  logic acc;
  logic wr;
  logic rd;
  logic hit_csr;
  logic hit_rxbuf;
  logic hit_stat;
  logic hit_mask;
  logic hit_vec;
  logic hit_any;
  logic line_change_evt;
  logic chg_irq;
  logic rx_irq;
  logic [15:0] modem_rx_control_status;
  logic [31:0] rd_data;
  logic [amcs_pkg::AMCS_EV_W-1:0] ev_set;

  // the ack pulse stays one cycle; a held request is not acked in two cycles in a row
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign hit_csr = wb_adr_i == amcs_pkg::AMCS_OFF_CSR;
  assign hit_rxbuf = wb_adr_i == amcs_pkg::AMCS_OFF_RXBUF;
  assign hit_stat = wb_adr_i == amcs_pkg::AMCS_OFF_IRQ_STAT;
  assign hit_mask = wb_adr_i == amcs_pkg::AMCS_OFF_IRQ_MASK;
  assign hit_vec = wb_adr_i == amcs_pkg::AMCS_OFF_VECTOR;
  assign hit_any = hit_csr || hit_rxbuf || hit_stat || hit_mask || hit_vec;
  assign acc = ce_i && req && hit_any;
  assign wr = acc && wb_we_i;
  assign rd = acc && !wb_we_i;

  // ring counts only on its rising edge, the others on both
  assign line_change_evt = (modem_i.carrier ^ prev_q.carrier) // R1
    || (modem_i.cts ^ prev_q.cts)
    || (modem_i.rev_in ^ prev_q.rev_in)
    || (modem_i.dsr ^ prev_q.dsr) // R8
    || (modem_i.ring && !prev_q.ring);

  always_comb begin
    modem_rx_control_status = amcs_pkg::AMCS_CSR_RESET; // R17
    modem_rx_control_status[amcs_pkg::AMCS_B_CHG] = line_change_flag_q;
    modem_rx_control_status[amcs_pkg::AMCS_B_RING] = prev_q.ring; // R4
    modem_rx_control_status[amcs_pkg::AMCS_B_CTS] = prev_q.cts; // R5
    modem_rx_control_status[amcs_pkg::AMCS_B_CAR] = prev_q.carrier; // R6
    modem_rx_control_status[amcs_pkg::AMCS_B_SREC] = prev_q.rev_in; // R7
    modem_rx_control_status[amcs_pkg::AMCS_B_DSR] = prev_q.dsr; // R8
    modem_rx_control_status[amcs_pkg::AMCS_B_DONE] = rx_char_complete_q;
    modem_rx_control_status[amcs_pkg::AMCS_B_RXIE] = rx_irq_enable_q;
    modem_rx_control_status[amcs_pkg::AMCS_B_CHGIE] = line_change_irq_enable_q;
    modem_rx_control_status[amcs_pkg::AMCS_B_SXMT] = ctl_q.rev_out;
    modem_rx_control_status[amcs_pkg::AMCS_B_RTS] = ctl_q.rts;
    modem_rx_control_status[amcs_pkg::AMCS_B_DTR] = ctl_q.dtr;
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_csr) begin
      rd_data = {16'h0000, modem_rx_control_status};
    end else if (hit_rxbuf) begin
      rd_data[DATA_W-1:0] = rx_data_holding_reg_q;
    end else if (hit_stat) begin
      rd_data[amcs_pkg::AMCS_EV_W-1:0] = ev_stat_q;
    end else if (hit_mask) begin
      rd_data[amcs_pkg::AMCS_EV_W-1:0] = ev_mask_q;
    end else if (hit_vec) begin
      rd_data[8:0] = irq_vector_o;
    end
  end

  // bus answer: ack or err one cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= req && hit_any;
      wb_err_o <= req && !hit_any;
      wb_dat_o <= rd ? rd_data : 32'h0000_0000;
    end
  end

  // sampled modem lines; the status bits read from these flops
  // sampling during init as well keeps a line held through it from faking a change
  always_ff @(posedge clk_i) begin
    if (rst_i || ce_i) begin
      prev_q <= modem_i;
    end
  end

  // a change in the same cycle as the clearing read wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_change_flag_q <= 1'b0; // R2
    end else if (ce_i) begin
      if (line_change_evt) begin
        line_change_flag_q <= 1'b1; // R1
      end else if (rd && hit_csr) begin
        line_change_flag_q <= 1'b0; // R2
      end
    end
  end

  // any access to the data buffer clears done; a new character wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_char_complete_q <= 1'b0; // R10
      rx_data_holding_reg_q <= '0;
    end else if (ce_i) begin
      if (rx_char_complete_i) begin
        rx_char_complete_q <= 1'b1; // R9
        rx_data_holding_reg_q <= rx_data_i;
      end else if (acc && hit_rxbuf) begin
        rx_char_complete_q <= 1'b0; // R10
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_data_read_o <= 1'b0;
    end else if (ce_i) begin
      rx_data_read_o <= acc && hit_rxbuf;
    end
  end

  // writable control bits; byte lane 0 holds all of them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_irq_enable_q <= 1'b0; // R11
      line_change_irq_enable_q <= 1'b0; // R12
      ctl_q <= '0; // R13 R14 R15
    end else if (ce_i && wr && hit_csr && wb_sel_i[0]) begin
      rx_irq_enable_q <= wb_dat_i[amcs_pkg::AMCS_B_RXIE]; // R11
      line_change_irq_enable_q <= wb_dat_i[amcs_pkg::AMCS_B_CHGIE]; // R12
      ctl_q.rev_out <= wb_dat_i[amcs_pkg::AMCS_B_SXMT]; // R13
      ctl_q.rts <= wb_dat_i[amcs_pkg::AMCS_B_RTS]; // R14
      ctl_q.dtr <= wb_dat_i[amcs_pkg::AMCS_B_DTR]; // R15
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      modem_o <= '0;
      async_mode_o <= 1'b1; // R16
    end else if (ce_i) begin
      modem_o <= ctl_q; // R13 R14 R15
      async_mode_o <= 1'b1; // R16
    end
  end

  assign chg_irq = line_change_flag_q && line_change_irq_enable_q; // R3
  assign rx_irq = rx_char_complete_q && rx_irq_enable_q; // R9
  assign ev_set = {rx_char_complete_i, line_change_evt};

  // sticky event status, write one to clear; a set in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_stat_q <= amcs_pkg::AMCS_EV_RESET;
      ev_mask_q <= amcs_pkg::AMCS_EV_RESET;
    end else if (ce_i) begin
      if (wr && hit_stat && wb_sel_i[0]) begin
        ev_stat_q <= (ev_stat_q & ~wb_dat_i[amcs_pkg::AMCS_EV_W-1:0]) | ev_set;
      end else begin
        ev_stat_q <= ev_stat_q | ev_set;
      end
      if (wr && hit_mask && wb_sel_i[0]) begin
        ev_mask_q <= wb_dat_i[amcs_pkg::AMCS_EV_W-1:0];
      end
    end
  end

  // line change has the higher priority at the shared output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      irq_vector_o <= amcs_pkg::AMCS_VEC_CHG;
    end else if (ce_i) begin
      irq_o <= (chg_irq && ev_mask_q[amcs_pkg::AMCS_EV_CHG]) // R3
        || (rx_irq && ev_mask_q[amcs_pkg::AMCS_EV_DONE]) // R9
        || |(ev_stat_q & ev_mask_q & ~{rx_irq_enable_q, line_change_irq_enable_q});
      irq_vector_o <= chg_irq ? amcs_pkg::AMCS_VEC_CHG : amcs_pkg::AMCS_VEC_RX; // R3
    end
  end

endmodule // amcs_top

// ### core/amcs_pkg.sv
/*
  Package for the modem control/status block: register offsets, bit positions,
  reset values and the packed carriers used by the top module.
  Assumes a 32-bit classic Wishbone slave with word addressing on byte addresses.
*/
package amcs_pkg;

  // register byte offsets (word aligned)
  localparam logic [7:0] AMCS_OFF_CSR = 8'h00;
  localparam logic [7:0] AMCS_OFF_RXBUF = 8'h04;
  localparam logic [7:0] AMCS_OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] AMCS_OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] AMCS_OFF_VECTOR = 8'h10;

  // control/status bit positions
  localparam int AMCS_B_CHG = 15;
  localparam int AMCS_B_RING = 14;
  localparam int AMCS_B_CTS = 13;
  localparam int AMCS_B_CAR = 12;
  localparam int AMCS_B_SREC = 10;
  localparam int AMCS_B_DSR = 9;
  localparam int AMCS_B_DONE = 7;
  localparam int AMCS_B_RXIE = 6;
  localparam int AMCS_B_CHGIE = 5;
  localparam int AMCS_B_SXMT = 3;
  localparam int AMCS_B_RTS = 2;
  localparam int AMCS_B_DTR = 1;

  // bits software may write in the control/status register
  localparam logic [15:0] AMCS_CSR_WMASK = 16'h006E;
  localparam logic [15:0] AMCS_CSR_RESET = 16'h0000;

  // interrupt vectors (octal 330 and its receive-done neighbour octal 60)
  localparam logic [8:0] AMCS_VEC_CHG = 9'h0D8;
  localparam logic [8:0] AMCS_VEC_RX = 9'h030;

  // sticky event bits of the interrupt status register
  localparam int AMCS_EV_CHG = 0;
  localparam int AMCS_EV_DONE = 1;
  localparam int AMCS_EV_W = 2;
  localparam logic [1:0] AMCS_EV_RESET = 2'h0;

  // modem inputs sampled together
  typedef struct packed {
    logic ring;
    logic cts;
    logic carrier;
    logic rev_in;
    logic dsr;
  } amcs_modem_in_t;

  // modem outputs driven together
  typedef struct packed {
    logic rev_out;
    logic rts;
    logic dtr;
  } amcs_modem_out_t;

endpackage : amcs_pkg

// ### verification/amcs_properties.sv
/* Checker for amcs_top, bound to every instance.
   Assumes a classic Wishbone master that idles between requests. */
module amcs_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire amcs_pkg::amcs_modem_in_t modem_i,
  input wire amcs_pkg::amcs_modem_out_t modem_o,
  input wire logic rx_data_read_o,
  input wire logic async_mode_o,
  input wire logic irq_o,
  input wire logic [8:0] irq_vector_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  logic csr_rd;
  assign req = wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && !wb_err_o;
  assign csr_rd = wb_ack_o && !wb_we_i && wb_adr_i == 8'h00;
  ack_latency_a: assert property (req |=> wb_ack_o || wb_err_o)
    else $error("no answer after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  unmapped_err_a: assert property (req && wb_adr_i > 8'h10 |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  ctl_outputs_a: assert property (
    req && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00 |-> ##2 modem_o == $past(wb_dat_i[3:1], 2))
    else $error("modem outputs miss control write");
  status_mirror_a: assert property (
    csr_rd && modem_i == $past(modem_i) && modem_i == $past(modem_i, 2)
    |-> {wb_dat_o[14:12], wb_dat_o[10:9]} == modem_i)
    else $error("status bits differ from modem lines");
  unused_zero_a: assert property (csr_rd |-> (wb_dat_o & 32'hFFFF0911) == 32'h0)
    else $error("unused bits not zero");
  rx_read_a: assert property (req && wb_adr_i == 8'h04 |=> rx_data_read_o)
    else $error("buffer access strobe missing");
  vector_a: assert property (irq_o |-> irq_vector_o inside {9'h0D8, 9'h030})
    else $error("bad vector");
  async_a: assert property (async_mode_o)
    else $error("not in async mode");
  reset_quiet_a: assert property ($fell(rst_i) |-> !irq_o && modem_o == 3'h0)
    else $error("outputs active after init");
  cover property (csr_rd);
  cover property (irq_o && irq_vector_o == 9'h030);
  cover property (wb_err_o);
endmodule // amcs_properties

bind amcs_top amcs_properties chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .modem_i, .modem_o,
  .rx_data_read_o, .async_mode_o, .irq_o, .irq_vector_o);

// ### verification/amcs_modem_model.sv
/* Behavioural modem on the far side of the control lines.
   Assumes the bench sets ring, cts, carrier and reverse lines. */
module amcs_modem_model (
  input wire logic clk_i,
  input wire logic [3:0] lines_i,
  input wire amcs_pkg::amcs_modem_out_t ctl_i,
  output amcs_pkg::amcs_modem_in_t modem_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ready_q = 1'b0;
  // ready follows terminal-ready a cycle late, so connect shows as a line change
  always @(posedge clk_i) ready_q <= ctl_i.dtr;
  assign modem_o = {lines_i, ready_q};
endmodule // amcs_modem_model

// ### verification/async_modem_control_status_tb.sv
/* Self-checking bench for amcs_top over Wishbone.
   Assumes the package register map and the modem model. */
module async_modem_control_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, we = 1'b0, rxc = 1'b0;
  logic [3:0] sel = 4'hF, lines = 4'h0;
  logic [7:0] adr = 8'h00, rxd = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, base;
  logic rflag;
  wire logic [31:0] dato;
  wire logic ack, err, rxr, amode, irq;
  wire logic [8:0] vec;
  wire amcs_pkg::amcs_modem_in_t mi;
  wire amcs_pkg::amcs_modem_out_t mo;
  int n_errors = 0, compares = 0;
  int pos[4] = '{10, 12, 13, 14};
  always #10 clk_i = ~clk_i;
  amcs_top dut (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
    .wb_err_o(err), .modem_i(mi), .modem_o(mo), .rx_char_complete_i(rxc), .rx_data_i(rxd),
    .rx_data_read_o(rxr), .async_mode_o(amode), .irq_o(irq), .irq_vector_o(vec));
  amcs_modem_model peer (.clk_i, .lines_i(lines), .ctl_i(mo), .modem_o(mi));
  task automatic wrap_up;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      i++;
    end while (!(ack || err) && i < 20);
    rdat = dato;
    rflag = rxr;
    cyc <= 1'b0;
    if (i == 20) begin
      n_errors++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rdat, e);
  endtask
  task automatic rx_pulse;
    rxd <= 8'hA5;
    rxc <= 1'b1;
    @(posedge clk_i);
    rxc <= 1'b0;
    idle(2);
  endtask
  initial begin
    idle(16);
    rst_i <= 1'b0;
    rd(8'h00, 32'h0);
    chk({31'h0, amode}, 32'h1);
    bus(8'h00, 1'b1, 32'hFFFF);
    idle(3);
    chk({29'h0, mo}, 32'h7);
    rd(8'h00, 32'h826E);
    base = 32'h026E;
    rd(8'h00, base);
    for (int k = 0; k < 4; k++) begin
      lines[k] <= 1'b1;
      idle(3);
      rd(8'h00, base | (32'h1 << pos[k]) | 32'h8000);
      lines[k] <= 1'b0;
      idle(3);
      rd(8'h00, (k == 3) ? base : base | 32'h8000);
    end
    bus(8'h0C, 1'b1, 32'h3);
    lines[2] <= 1'b1;
    idle(3);
    chk({22'h0, irq, vec}, {22'h0, 1'b1, 9'h0D8});
    base = base | 32'h2000;
    rd(8'h00, base | 32'h8000);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    bus(8'h08, 1'b1, 32'h3);
    rd(8'h08, 32'h0);
    rx_pulse();
    chk({22'h0, irq, vec}, {22'h0, 1'b1, 9'h030});
    rd(8'h00, base | 32'h80);
    rd(8'h04, 32'hA5);
    chk({31'h0, rflag}, 32'h1);
    rd(8'h00, base);
    idle(1);
    chk({31'h0, irq}, 32'h0);
    // masked source: flag still sets but no interrupt may follow
    bus(8'h0C, 1'b1, 32'h1);
    rx_pulse();
    chk({31'h0, irq}, 32'h0);
    rd(8'h04, 32'hA5);
    sel <= 4'hE;
    bus(8'h00, 1'b1, 32'h0);
    sel <= 4'hF;
    rd(8'h00, base);
    bus(8'h14, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    rst_i <= 1'b1;
    idle(16);
    rst_i <= 1'b0;
    rd(8'h00, 32'h2000);
    chk({28'h0, irq, mo}, 32'h0);
    chk({31'h0, amode}, 32'h1);
    wrap_up();
  end
endmodule // async_modem_control_status_tb
